// ==== spcfg_pkg.sv ====
// Constants shared by the transceiver PLL configuration block.
// Assumes a single 10 MHz reference clock drives all logic.
package spcfg_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int          CLK_PERIOD_NS   = 100;
   localparam int          SETTLE_TIME_NS  = 1000;
   localparam int          SETTLE_CYCLES   = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          LOCK_CYCLES     = 200;
   localparam int          CNT_W           = 8;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int          ADDR_W          = 8;
   localparam logic [7:0]  ADDR_CONFIG0    = 8'h00;
   localparam logic [7:0]  ADDR_LINK_PD    = 8'h04;
   localparam logic [7:0]  ADDR_STATUS     = 8'h08;
   localparam int          NUM_LINKS       = 4;

   // ----------------------------------------------------------------
   // Configuration register fields
   // ----------------------------------------------------------------
   localparam int          ENABLE_POS      = 0;
   localparam int          MPY_LSB         = 1;
   localparam int          MPY_MSB         = 5;
   localparam int          LB_LSB          = 8;
   localparam int          LB_MSB          = 9;
   localparam logic [31:0] CONFIG0_RESET   = 32'h0000_0000;
   localparam logic [31:0] CONFIG0_RW_MASK = 32'h0000_033f;
   localparam logic [3:0]  LINK_PD_RESET   = 4'h0;

   // Multiply codes
   localparam logic [4:0]  MPY_4X          = 5'h00;
   localparam logic [4:0]  MPY_25X         = 5'h0a;
   localparam logic [4:0]  MPY_RSVD        = 5'h03;

   // Loop bandwidth codes
   localparam logic [1:0]  LB_NORMAL       = 2'h0;
   localparam logic [1:0]  LB_RSVD         = 2'h1;
   localparam logic [1:0]  LB_LOW          = 2'h2;
   localparam logic [1:0]  LB_HIGH         = 2'h3;

   // Bandwidth as a divisor of the reference frequency
   localparam logic [4:0]  BW_DIV_NORMAL   = 5'h0c;
   localparam logic [4:0]  BW_DIV_LOW      = 5'h14;
   localparam logic [4:0]  BW_DIV_HIGH     = 5'h08;

   // Sequencer states
   typedef enum logic [1:0] {
      SPCFG_IDLE   = 2'b00,
      SPCFG_SETTLE = 2'b01,
      SPCFG_LOCK   = 2'b10,
      SPCFG_READY  = 2'b11
   } spcfg_state_t;

endpackage : spcfg_pkg

// ==== spcfg_seq.sv ====
// Enable sequencer: regulator settle wait, then lock wait.
// Assumes i_enable is a level synchronous to i_ref_clk.
`timescale 1ns/1ns
module spcfg_seq (
   // Clock and reset
   input  wire logic i_ref_clk,
   input  wire logic i_reset_n,
   // Control
   input  wire logic i_enable,
   // Status
   output logic      o_lock_pending,
   output logic      o_ready
);
   import spcfg_pkg::*;

   spcfg_state_t     state;
   spcfg_state_t     next_state;
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;
   logic [CNT_W-1:0] en_age;
   logic [CNT_W-1:0] next_en_age;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_count = count;
      if (!i_enable) begin
         next_state = SPCFG_IDLE;                          // see RULE15
         next_count = '0;
      end else begin
         case (state)
            SPCFG_IDLE: begin
               next_state = SPCFG_SETTLE;
               next_count = CNT_W'(SETTLE_CYCLES - 1);
            end
            SPCFG_SETTLE: begin
               if (count == '0) begin                      // see RULE2
                  next_state = SPCFG_LOCK;
                  next_count = CNT_W'(LOCK_CYCLES - 1);
               end else begin
                  next_count = count - 1'b1;
               end
            end
            SPCFG_LOCK: begin
               if (count == '0) begin                      // see RULE3
                  next_state = SPCFG_READY;
               end else begin
                  next_count = count - 1'b1;
               end
            end
            SPCFG_READY: begin
               next_state = SPCFG_READY;
            end
            default: begin
               next_state = SPCFG_IDLE;
               next_count = '0;
            end
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state <= SPCFG_IDLE;
         count <= '0;
      end else begin
         state <= next_state;
         count <= next_count;
      end
   end

   assign o_lock_pending = (state == SPCFG_SETTLE) || (state == SPCFG_LOCK);   // see RULE15
   assign o_ready        = (state == SPCFG_READY);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Cycles since enable went high, saturating; feeds the ready check
   always_comb begin
      next_en_age = en_age;
      if (!i_enable) begin
         next_en_age = '0;
      end else if (en_age != '1) begin
         next_en_age = en_age + 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         en_age <= '0;
      end else begin
         en_age <= next_en_age;
      end
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);

   sequence s_enable_rise;
      !i_enable ##1 i_enable;
   endsequence

   chk_pending_span: assert property (                                // see RULE15
      s_enable_rise |=> o_lock_pending [*8] ##0 (!i_enable or o_lock_pending))
      else $error("lock pending dropped during settle");

   chk_ready_time: assert property (                                  // see RULE3
      (i_enable && (en_age >= CNT_W'(SETTLE_CYCLES + LOCK_CYCLES + 1))) |-> o_ready)
      else $error("ready not reached after settle plus lock count");

   chk_not_early: assert property (                                   // see RULE2
      s_enable_rise |=> !o_ready [*8])
      else $error("ready asserted before settle interval");

   chk_disable_clear: assert property (                               // see RULE15
      !i_enable |=> !o_lock_pending && !o_ready)
      else $error("status not cleared after disable");

endmodule : spcfg_seq

// ==== spcfg_top.sv ====
// Transceiver PLL configuration register, link power-down and enable sequencing.
// Assumes a plain register port synchronous to i_ref_clk; i_pll_lock_raw is asynchronous.
//
// Operation
// RULE1 - Enable bit switches PLL on, clear keeps off
// RULE2 - Wait 1 us regulator settle after enable
// RULE3 - Lock within 200 reference cycles after settle
// RULE4 - Enable bit0, multiply 5:1, bandwidth 9:8
// RULE5 - Bandwidth code 00 gives reference over twelve
// RULE6 - Code 10 gives over twenty, floor 3 MHz
// RULE7 - Code 11 gives reference over eight
// RULE8 - Software never selects 8-bit PLL mode
// RULE9 - Multiplied clock stays inside the macro
// RULE10 - Status crossing clock domains gets synchronised
// RULE11 - Fields reset zero; reserved bits read-only
// RULE12 - Each unused link powers down independently
// RULE13 - Five-bit multiply code selects 4x to 60x
// RULE14 - Reserved bandwidth or multiply codes are invalid
// RULE15 - Lock pending from enable until timers elapse
`timescale 1ns/1ns
module spcfg_top (
   // Clock and reset
   input  wire logic                          i_ref_clk,
   input  wire logic                          i_reset_n,
   // Register port
   input  wire logic [spcfg_pkg::ADDR_W-1:0]  i_addr,
   input  wire logic [31:0]                   i_wdata,
   input  wire logic                          i_write,
   input  wire logic                          i_read,
   output logic      [31:0]                   o_rdata,
   // PLL macro control; the multiplied clock never leaves the macro
   output logic                               o_pll_power_on,
   output logic      [4:0]                    o_pll_multiply_sel,
   output logic      [1:0]                    o_loop_bandwidth_sel,
   output logic      [4:0]                    o_loop_bw_div,
   output logic                               o_loop_bw_floor,
   output logic                               o_pll_ten_bit,
   // PLL macro status
   input  wire logic                          i_pll_lock_raw,
   // Link power
   output logic      [spcfg_pkg::NUM_LINKS-1:0] o_link_powerdown,
   output logic      [spcfg_pkg::NUM_LINKS-1:0] o_link_active,
   // Sequencer status
   output logic                               o_lock_pending,
   output logic                               o_pll_ready
);
   import spcfg_pkg::*;

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [31:0]          config0;
   logic [31:0]          next_config0;
   logic [NUM_LINKS-1:0] link_pd;
   logic [NUM_LINKS-1:0] next_link_pd;
   logic [31:0]          rdata;
   logic [31:0]          next_rdata;
   logic [1:0]           lock_sync;
   logic [1:0]           next_lock_sync;
   logic [4:0]           bw_div;
   logic [4:0]           next_bw_div;
   logic                 bw_floor;
   logic                 next_bw_floor;

   logic                 pll_enable_bit;
   logic [4:0]           pll_multiply_sel;
   logic [1:0]           loop_bandwidth_sel;
   logic                 cfg_invalid;
   logic                 seq_enable;
   logic                 seq_pending;
   logic                 seq_ready;
   logic [31:0]          status_word;

   assign pll_enable_bit     = config0[ENABLE_POS];            // see RULE4
   assign pll_multiply_sel   = config0[MPY_MSB:MPY_LSB];
   assign loop_bandwidth_sel = config0[LB_MSB:LB_LSB];

   // Reserved codes hold the PLL off
   assign cfg_invalid = (loop_bandwidth_sel == LB_RSVD) ||
                        (pll_multiply_sel == MPY_RSVD);       // see RULE14
   assign seq_enable  = pll_enable_bit && !cfg_invalid;        // see RULE1

   assign status_word = {26'h0000000, cfg_invalid, lock_sync[1],
                         seq_ready, seq_pending, 1'b0, pll_enable_bit};

   // ----------------------------------------------------------------
   // Register writes and reads
   // ----------------------------------------------------------------
   always_comb begin
      next_config0 = config0;
      next_link_pd = link_pd;
      next_rdata   = 32'h0000_0000;
      if (i_write && (i_addr == ADDR_CONFIG0)) begin
         next_config0 = i_wdata & CONFIG0_RW_MASK;             // see RULE11
      end
      if (i_write && (i_addr == ADDR_LINK_PD)) begin
         next_link_pd = i_wdata[NUM_LINKS-1:0];
      end
      if (i_read) begin
         case (i_addr)
            ADDR_CONFIG0: next_rdata = config0;
            ADDR_LINK_PD: next_rdata = {28'h0000000, link_pd};
            ADDR_STATUS:  next_rdata = status_word;
            default:      next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         config0 <= CONFIG0_RESET;                             // see RULE11
         link_pd <= LINK_PD_RESET;
         rdata   <= 32'h0000_0000;
      end else begin
         config0 <= next_config0;
         link_pd <= next_link_pd;
         rdata   <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // Lock status synchroniser and bandwidth decode
   // ----------------------------------------------------------------
   always_comb begin
      next_lock_sync = {lock_sync[0], i_pll_lock_raw};         // see RULE10
      next_bw_floor  = 1'b0;
      case (loop_bandwidth_sel)
         LB_NORMAL: next_bw_div = BW_DIV_NORMAL;               // see RULE5
         LB_LOW: begin
            next_bw_div   = BW_DIV_LOW;                        // see RULE6
            next_bw_floor = 1'b1;
         end
         LB_HIGH:   next_bw_div = BW_DIV_HIGH;                 // see RULE7
         default:   next_bw_div = 5'h00;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         lock_sync <= 2'h0;
         bw_div    <= 5'h00;
         bw_floor  <= 1'b0;
      end else begin
         lock_sync <= next_lock_sync;
         bw_div    <= next_bw_div;
         bw_floor  <= next_bw_floor;
      end
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   spcfg_seq u_seq (
      .i_ref_clk      (i_ref_clk),
      .i_reset_n      (i_reset_n),
      .i_enable       (seq_enable),
      .o_lock_pending (seq_pending),
      .o_ready        (seq_ready)
   );

   // ----------------------------------------------------------------
   // Link power, one control per link
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_LINKS; g++) begin : g_link
         assign o_link_powerdown[g] = link_pd[g];              // see RULE12
         assign o_link_active[g]    = !link_pd[g] && seq_ready;
      end
   endgenerate

   // ----------------------------------------------------------------
   // Outputs; only control levels leave, never the fast clock
   // ----------------------------------------------------------------
   assign o_pll_power_on       = seq_enable;                   // see RULE9
   assign o_pll_multiply_sel   = pll_multiply_sel;             // see RULE13
   assign o_loop_bandwidth_sel = loop_bandwidth_sel;
   assign o_loop_bw_div        = bw_div;
   assign o_loop_bw_floor      = bw_floor;
   assign o_pll_ten_bit        = 1'b1;                         // see RULE8
   assign o_rdata              = rdata;
   assign o_lock_pending       = seq_pending;
   assign o_pll_ready          = seq_ready;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);

   chk_reserved_zero: assert property (                               // see RULE11
      (config0 & ~CONFIG0_RW_MASK) == 32'h0000_0000)
      else $error("reserved config bits not zero");

   chk_read_data: assert property (                                   // see RULE4
      (i_read && i_addr == ADDR_CONFIG0 && !i_write) |=> (o_rdata == $past(config0)))
      else $error("config read data wrong");

   chk_bw_div: assert property (                                      // see RULE6
      (loop_bandwidth_sel == LB_LOW) |=> (o_loop_bw_div == BW_DIV_LOW) && o_loop_bw_floor)
      else $error("low bandwidth decode wrong");

   chk_bw_normal: assert property (                                   // see RULE5
      (loop_bandwidth_sel == LB_NORMAL) |=> (o_loop_bw_div == BW_DIV_NORMAL))
      else $error("normal bandwidth decode wrong");

   chk_invalid_off: assert property (                                 // see RULE14
      cfg_invalid |-> !o_pll_power_on ##1 !o_pll_ready)
      else $error("PLL powered with reserved code");

   chk_sync_delay: assert property (                                  // see RULE10
      $rose(i_pll_lock_raw) |-> ##2 lock_sync[1])
      else $error("lock status sync latency wrong");

   chk_link_pd: assert property (                                     // see RULE12
      o_link_active[0] |-> !link_pd[0] && seq_ready)
      else $error("powered down link reported active");

endmodule : spcfg_top

// ==== serdes_pll_config_tb.sv ====
// Self-checking bench for the transceiver PLL configuration block.
// Assumes the spcfg_pkg package and the spcfg_top module are compiled first.
`timescale 1ns/1ns
module serdes_pll_config_tb;
   import spcfg_pkg::*;

   // ----------------------------------------------------------------
   // Signals and model state
   // ----------------------------------------------------------------
   logic                 i_ref_clk;
   logic                 i_reset_n;
   logic [ADDR_W-1:0]    i_addr;
   logic [31:0]          i_wdata;
   logic                 i_write;
   logic                 i_read;
   logic                 i_pll_lock_raw;
   logic [31:0]          o_rdata;
   logic                 o_pll_power_on;
   logic [4:0]           o_pll_multiply_sel;
   logic [1:0]           o_loop_bandwidth_sel;
   logic [4:0]           o_loop_bw_div;
   logic                 o_loop_bw_floor;
   logic                 o_pll_ten_bit;
   logic [NUM_LINKS-1:0] o_link_powerdown;
   logic [NUM_LINKS-1:0] o_link_active;
   logic                 o_lock_pending;
   logic                 o_pll_ready;
   logic [31:0]          m_cfg;
   logic [31:0]          m_pd;
   logic [31:0]          d;
   logic [4:0]           bw_tab [4] = '{BW_DIV_NORMAL, 5'h00, BW_DIV_LOW, BW_DIV_HIGH};
   int                   n_mismatch = 0;
   int                   n_tests = 0;
   int                   seed = 58294;
   int                   k;
   int                   p;

   spcfg_top DUT (
      .i_ref_clk            (i_ref_clk),
      .i_reset_n            (i_reset_n),
      .i_addr               (i_addr),
      .i_wdata              (i_wdata),
      .i_write              (i_write),
      .i_read               (i_read),
      .o_rdata              (o_rdata),
      .o_pll_power_on       (o_pll_power_on),
      .o_pll_multiply_sel   (o_pll_multiply_sel),
      .o_loop_bandwidth_sel (o_loop_bandwidth_sel),
      .o_loop_bw_div        (o_loop_bw_div),
      .o_loop_bw_floor      (o_loop_bw_floor),
      .o_pll_ten_bit        (o_pll_ten_bit),
      .i_pll_lock_raw       (i_pll_lock_raw),
      .o_link_powerdown     (o_link_powerdown),
      .o_link_active        (o_link_active),
      .o_lock_pending       (o_lock_pending),
      .o_pll_ready          (o_pll_ready)
   );

   always #50 i_ref_clk = ~i_ref_clk;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic conclude;
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : conclude

   // Returns just after the edge that takes the write
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge i_ref_clk);
      i_addr  <= a;
      i_wdata <= v;
      i_write <= 1'b1;
      @(posedge i_ref_clk);
      i_write <= 1'b0;
      #1;
      if (a == ADDR_CONFIG0) m_cfg = v & CONFIG0_RW_MASK;
      if (a == ADDR_LINK_PD) m_pd = {28'h0, v[3:0]};
   endtask : wr

   // Data stand one cycle after the taking edge, then return to zero
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_read <= 1'b1;
      @(posedge i_ref_clk);
      i_read <= 1'b0;
      #1;
      chk(o_rdata, exp);
      @(posedge i_ref_clk);
      #1;
      chk(o_rdata, 32'h0);
   endtask : rd

   task automatic chk_cfg;
      chk(o_pll_multiply_sel, m_cfg[5:1]);
      chk(o_loop_bandwidth_sel, m_cfg[9:8]);
      chk(o_pll_power_on, m_cfg[0] & (m_cfg[9:8] != LB_RSVD) & (m_cfg[5:1] != MPY_RSVD));
   endtask : chk_cfg

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      i_ref_clk = 1'b0;
      i_reset_n = 1'b0;
      i_addr = 8'h00;
      i_wdata = 32'h0;
      i_write = 1'b0;
      i_read = 1'b0;
      i_pll_lock_raw = 1'b0;
      m_cfg = 32'h0;
      m_pd = 32'h0;
      repeat (8) @(posedge i_ref_clk);
      i_reset_n <= 1'b1;
      @(posedge i_ref_clk);
      #1;
      chk(o_loop_bw_div, BW_DIV_NORMAL);
      chk(o_pll_ten_bit, 1'b1);
      chk(o_pll_power_on, 1'b0);
      rd(ADDR_CONFIG0, CONFIG0_RESET);
      rd(ADDR_LINK_PD, 32'h0);
      rd(ADDR_STATUS, 32'h0);
      wr(ADDR_CONFIG0, 32'hffff_fcc0);
      rd(ADDR_CONFIG0, 32'h0);
      for (int i = 0; i < 4; i++) begin
         d = $random(seed);
         d[0] = 1'b0;
         wr(ADDR_CONFIG0, d);
         chk_cfg();
         rd(ADDR_CONFIG0, m_cfg);
      end
      // Every bandwidth code, multiply 25x, PLL off
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_CONFIG0, {22'h0, i[1:0], 8'h14});
         @(posedge i_ref_clk);
         #1;
         chk(o_loop_bw_div, bw_tab[i]);
         chk(o_loop_bw_floor, i == 2);
         chk(o_pll_multiply_sel, MPY_25X);
      end
      // Reserved codes keep the PLL off
      wr(ADDR_CONFIG0, 32'h0000_0115);
      chk_cfg();
      rd(ADDR_STATUS, 32'h21);
      wr(ADDR_CONFIG0, 32'h0000_0007);
      chk_cfg();
      chk(o_lock_pending, 1'b0);
      wr(ADDR_CONFIG0, 32'h0);
      // Enable sequence, settle then lock
      @(posedge i_ref_clk);
      i_pll_lock_raw <= 1'b1;
      wr(ADDR_CONFIG0, 32'h0000_0015);
      chk_cfg();
      k = 0;
      p = 0;
      while (o_pll_ready !== 1'b1 && k < 400) begin
         @(posedge i_ref_clk);
         #1;
         k++;
         if (o_lock_pending === 1'b1) p++;
      end
      if (k >= 400) begin
         n_mismatch++;
         conclude();
      end
      chk(k, SETTLE_CYCLES + LOCK_CYCLES + 1);
      chk(p, SETTLE_CYCLES + LOCK_CYCLES);
      rd(ADDR_STATUS, 32'h19);
      // Link power-down leaves other links running
      for (int i = 0; i < 3; i++) begin
         wr(ADDR_LINK_PD, $random(seed));
         chk(o_link_powerdown, m_pd[3:0]);
         chk(o_link_active, m_pd[3:0] ^ 4'hf);
      end
      rd(ADDR_LINK_PD, m_pd);
      wr(8'h0c, 32'hffff_ffff);
      rd(8'h0c, 32'h0);
      rd(ADDR_CONFIG0, m_cfg);
      // Disable drops pending and ready
      wr(ADDR_CONFIG0, 32'h0);
      chk(o_pll_power_on, 1'b0);
      @(posedge i_ref_clk);
      #1;
      chk({o_lock_pending, o_pll_ready}, 2'b00);
      chk(o_link_active, 4'h0);
      conclude();
   end
endmodule : serdes_pll_config_tb
